// >>> design/qie_engine.sv
`timescale 1ns/1ns
// Notes on behaviour
// - head advances past a descriptor only after it checks valid
// - 256-bit mode treats tail bit 4 as reserved with bits 3:0
// - ring empty whenever head equals tail
// - enable command sets queue_on_status
// - fetch in order only when on, non-empty, no error flags
// - disable zeroes head and clears queue_on_status
// - type is descriptor bits 11:9 above bits 3:0
// - type 1h is a context flush request
// - context flush descriptor in 256-bit mode with any of bits 255:128 set is an invalid descriptor
// - 128-bit context flush descriptors invalid in scalable or abort translation kinds
// - scope 01 global, 10 domain, 11 device; 00 invalid
// - scalable mode: domain scope becomes global, domain tag ignored
// - phantom_mask hides requester bits: none, 2, 2:1, 2:0
// - flush write buffer before each context flush when needed
// - entry_width_sel 0 means 128-bit, 1 means 256-bit only with scalable or abort support, else 128-bit
module qie_engine
#(
  parameter int ENTRY_LOG2_MAX = 15
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic queue_enable_cmd,
  output logic queue_on_status,
  input wire logic [qie_pkg::ADDR_W-1:0] queue_base_config,
  input wire logic [3:0] queue_size_log2,
  input wire logic entry_width_sel,
  input wire logic [qie_pkg::PTR_W-1:0] ring_tail,
  output logic [qie_pkg::PTR_W-1:0] ring_head,
  output logic queue_error_flag,
  input wire logic queue_error_clear,
  input wire logic timeout_error_flag,
  input wire logic [1:0] translation_kind,
  input wire logic scalable_support,
  input wire logic abort_support,
  input wire logic write_buffer_flush_needed,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [qie_pkg::ADDR_W-1:0] rd_addr,
  input wire logic data_valid,
  input wire logic [qie_pkg::DESC_W-1:0] data_desc,
  output logic flush_req,
  input wire logic flush_done,
  output logic context_flush_valid,
  input wire logic context_flush_ready,
  output qie_pkg::qie_req_t context_flush_request,
  output logic other_valid,
  input wire logic other_ready,
  output logic [6:0] other_kind
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_WAIT = 5'h04,
    ST_FLSH = 5'h08,
    ST_PUSH = 5'h10
  } qie_state_t;

  typedef struct packed {
    qie_state_t st;
    logic on;
    logic err;
    logic [qie_pkg::PTR_W-1:0] head;
    logic [qie_pkg::ADDR_W-1:0] addr;
    qie_pkg::qie_req_t req;
    logic is_ctx;
    logic other;
    logic [6:0] okind;
  } qie_st_t;

  localparam int PTR_W = qie_pkg::PTR_W;

  qie_st_t s_q;
  qie_st_t s_d;
  logic rst_m_q;
  logic rst_s_q;
  logic wide;
  logic [qie_pkg::PTR_W-1:0] tail_eff;
  logic [qie_pkg::PTR_W-1:0] last_off;
  logic [qie_pkg::PTR_W-1:0] step;
  logic [6:0] kind;
  logic [1:0] scope;
  logic upper_nz;
  logic bad;
  logic [15:0] rmask;
  logic can_fetch;
  qie_req_if sk_if();

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end
    else
    begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end

  // width only programmable when scalable or abort support exists
  assign wide = entry_width_sel && (scalable_support || abort_support);
  assign step = wide ? 19'h00020 : 19'h00010;
  // reserved low tail bits are dropped, never compared
  assign tail_eff = wide ? {ring_tail[qie_pkg::PTR_W-1:qie_pkg::BYTES256_LOG2], 5'h00}
                         : {ring_tail[qie_pkg::PTR_W-1:qie_pkg::BYTES128_LOG2], 4'h0};
  // byte offset of the last entry: 2^(12+size) bytes per ring
  assign last_off = PTR_W'(((20'h01000 << queue_size_log2) - 20'h1)) & ~(step - 19'h1);
  assign can_fetch = s_q.on && (s_q.head != tail_eff) && !s_q.err
                     && !timeout_error_flag;

  assign kind = {data_desc[qie_pkg::TYPE_HI_MSB:qie_pkg::TYPE_HI_LSB],
                 data_desc[qie_pkg::TYPE_LO_MSB:0]};
  assign scope = data_desc[qie_pkg::GRAN_MSB:qie_pkg::GRAN_LSB];
  assign upper_nz = |data_desc[qie_pkg::DESC_W-1:qie_pkg::HALF_W];

  always_comb
  begin
    bad = 1'b0;
    if (kind == qie_pkg::TYPE_CTX)
    begin
      if (scope == qie_pkg::GRAN_BAD)
      begin
        bad = 1'b1;
      end
      if (wide && upper_nz)
      begin
        bad = 1'b1;
      end
      if (!wide && ((translation_kind == qie_pkg::MODE_SCALABLE)
                    || (translation_kind == qie_pkg::MODE_ABORT)))
      begin
        bad = 1'b1;
      end
    end
  end

  always_comb
  begin
    case (data_desc[qie_pkg::MASK_MSB:qie_pkg::MASK_LSB])
      2'h0: rmask = 16'hFFFF;
      2'h1: rmask = 16'hFFFB;
      2'h2: rmask = 16'hFFF9;
      default: rmask = 16'hFFF8;
    endcase
  end

  always_comb
  begin
    s_d = s_q;
    if (queue_error_clear)
    begin
      s_d.err = 1'b0;
    end
    case (s_q.st)
      ST_IDLE:
      begin
        if (can_fetch)
        begin
          s_d.addr = queue_base_config + {45'h0, s_q.head};
          s_d.st = ST_ADDR;
        end
      end
      ST_ADDR:
      begin
        if (rd_ready)
        begin
          s_d.st = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        if (data_valid)
        begin
          if (bad)
          begin
            s_d.err = 1'b1;
            s_d.st = ST_IDLE;
          end
          else
          begin
            s_d.is_ctx = (kind == qie_pkg::TYPE_CTX);
            s_d.other = (kind != qie_pkg::TYPE_CTX);
            s_d.okind = kind;
            s_d.req.kind = kind;
            s_d.req.scope = scope;
            s_d.req.domain_tag = data_desc[qie_pkg::DOM_MSB:qie_pkg::DOM_LSB];
            s_d.req.requester_number = data_desc[qie_pkg::REQ_MSB:qie_pkg::REQ_LSB] & rmask;
            s_d.req.requester_mask = rmask;
            if (translation_kind == qie_pkg::MODE_SCALABLE)
            begin
              s_d.req.domain_tag = 16'h0000;
              if (scope == qie_pkg::GRAN_DOMAIN)
              begin
                s_d.req.scope = qie_pkg::GRAN_GLOBAL;
              end
            end
            // head moves only once the descriptor has passed checks
            s_d.head = (s_q.head >= last_off) ? qie_pkg::PTR_ZERO
                                              : s_q.head + step;
            s_d.st = ((kind == qie_pkg::TYPE_CTX) && write_buffer_flush_needed)
                     ? ST_FLSH : ST_PUSH;
          end
        end
      end
      ST_FLSH:
      begin
        if (flush_done)
        begin
          s_d.st = ST_PUSH;
        end
      end
      ST_PUSH:
      begin
        if (s_q.is_ctx && sk_if.ready)
        begin
          s_d.is_ctx = 1'b0;
        end
        if (s_q.other && other_ready)
        begin
          s_d.other = 1'b0;
        end
        if (!s_d.is_ctx && !s_d.other)
        begin
          s_d.st = ST_IDLE;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
    if (queue_enable_cmd)
    begin
      s_d.on = 1'b1;
    end
    else
    begin
      s_d.on = 1'b0;
      s_d.head = qie_pkg::PTR_ZERO;
    end
  end

  always_ff @(posedge clk or negedge rst_s_q)
  begin
    if (!rst_s_q)
    begin
      s_q <= '{st: ST_IDLE, default: '0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign sk_if.valid = (s_q.st == ST_PUSH) && s_q.is_ctx;
  assign sk_if.data = s_q.req;

  qie_skid u_skid
  (
    .clk(clk),
    .rst_n(rst_s_q),
    .in_if(sk_if),
    .out_valid(context_flush_valid),
    .out_ready(context_flush_ready),
    .out_data(context_flush_request)
  );

  assign queue_on_status = s_q.on;
  assign ring_head = s_q.head;
  assign queue_error_flag = s_q.err;
  assign rd_valid = (s_q.st == ST_ADDR);
  assign rd_addr = s_q.addr;
  assign flush_req = (s_q.st == ST_FLSH);
  assign other_valid = (s_q.st == ST_PUSH) && s_q.other;
  assign other_kind = s_q.okind;
endmodule

// >>> design/qie_pkg.sv
package qie_pkg;
  localparam int ADDR_W = 64;
  localparam int PTR_W = 19;
  localparam int DESC_W = 256;
  localparam int HALF_W = 128;
  localparam int BYTES128_LOG2 = 4;
  localparam int BYTES256_LOG2 = 5;
  localparam int TYPE_LO_MSB = 3;
  localparam int TYPE_HI_LSB = 9;
  localparam int TYPE_HI_MSB = 11;
  localparam int GRAN_LSB = 4;
  localparam int GRAN_MSB = 5;
  localparam int DOM_LSB = 16;
  localparam int DOM_MSB = 31;
  localparam int REQ_LSB = 32;
  localparam int REQ_MSB = 47;
  localparam int MASK_LSB = 48;
  localparam int MASK_MSB = 49;
  localparam logic [6:0] TYPE_CTX = 7'h01;
  localparam logic [1:0] GRAN_BAD = 2'h0;
  localparam logic [1:0] GRAN_GLOBAL = 2'h1;
  localparam logic [1:0] GRAN_DOMAIN = 2'h2;
  localparam logic [1:0] GRAN_DEVICE = 2'h3;
  localparam logic [1:0] MODE_SCALABLE = 2'h1;
  localparam logic [1:0] MODE_ABORT = 2'h3;
  localparam logic [PTR_W-1:0] PTR_ZERO = 19'h00000;

  typedef struct packed {
    logic [1:0] scope;
    logic [15:0] domain_tag;
    logic [15:0] requester_number;
    logic [15:0] requester_mask;
    logic [6:0] kind;
  } qie_req_t;
endpackage

// >>> design/qie_req_if.sv
`timescale 1ns/1ns
interface qie_req_if;
  logic valid;
  logic ready;
  qie_pkg::qie_req_t data;
  modport src(output valid, output data, input ready);
  modport dst(input valid, input data, output ready);
endinterface

// >>> design/qie_skid.sv
`timescale 1ns/1ns
module qie_skid
(
  input wire logic clk,
  input wire logic rst_n,
  qie_req_if.dst in_if,
  output logic out_valid,
  input wire logic out_ready,
  output qie_pkg::qie_req_t out_data
);
  typedef struct packed {
    logic [1:0] cnt;
    qie_pkg::qie_req_t e0;
    qie_pkg::qie_req_t e1;
  } qie_skid_st_t;

  qie_skid_st_t s_q;
  qie_skid_st_t s_d;
  logic push;
  logic pop;

  assign in_if.ready = (s_q.cnt != 2'h2);
  assign out_valid = (s_q.cnt != 2'h0);
  assign out_data = s_q.e0;
  assign push = in_if.valid && in_if.ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    s_d = s_q;
    if (pop)
    begin
      s_d.e0 = s_q.e1;
    end
    if (push)
    begin
      if ((s_q.cnt == 2'h0) || ((s_q.cnt == 2'h1) && pop))
      begin
        s_d.e0 = in_if.data;
      end
      else
      begin
        s_d.e1 = in_if.data;
      end
    end
    s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end
endmodule

// >>> tb/qie_chk_checker.sv
`timescale 1ns/1ns
module qie_chk
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic queue_enable_cmd,
  input wire logic queue_on_status,
  input wire logic [63:0] queue_base_config,
  input wire logic entry_width_sel,
  input wire logic [18:0] ring_tail,
  input wire logic [18:0] ring_head,
  input wire logic queue_error_flag,
  input wire logic timeout_error_flag,
  input wire logic rd_valid,
  input wire logic rd_ready,
  input wire logic [63:0] rd_addr,
  input wire logic flush_req,
  input wire logic flush_done,
  input wire logic context_flush_valid,
  input wire logic context_flush_ready,
  input wire qie_pkg::qie_req_t context_flush_request
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic [18:0] step;
  assign step = entry_width_sel ? 19'h00020 : 19'h00010;
  property p_on;
    queue_on_status == $past(queue_enable_cmd);
  endproperty
  a_on: assert property (p_on) else $error("status late");
  property p_off;
    !queue_on_status |-> ring_head == 19'h00000;
  endproperty
  a_off: assert property (p_off) else $error("head not zero");
  property p_fetch;
    $rose(rd_valid) |-> $past(queue_on_status && !queue_error_flag && !timeout_error_flag
      && ring_head != ring_tail);
  endproperty
  a_fetch: assert property (p_fetch) else $error("bad fetch");
  property p_addr;
    $rose(rd_valid) |-> rd_addr == queue_base_config + ring_head;
  endproperty
  a_addr: assert property (p_addr) else $error("bad address");
  property p_rd_hold;
    rd_valid && !rd_ready |=> rd_valid && $stable(rd_addr);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("fetch dropped");
  property p_err;
    queue_error_flag |=> $stable(ring_head) || !queue_on_status;
  endproperty
  a_err: assert property (p_err) else $error("head moved on error");
  property p_adv;
    $changed(ring_head) && queue_on_status |->
      !queue_error_flag && (ring_head == $past(ring_head) + step || ring_head == 19'h00000);
  endproperty
  a_adv: assert property (p_adv) else $error("bad head step");
  property p_flush;
    flush_req && !flush_done |=> flush_req;
  endproperty
  a_flush: assert property (p_flush) else $error("flush dropped");
  property p_out_hold;
    context_flush_valid && !context_flush_ready |=> context_flush_valid
      && $stable(context_flush_request);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("request lost");
  c_slow: cover property (rd_valid && !rd_ready);
  c_err: cover property ($rose(queue_error_flag));
  c_held: cover property (context_flush_valid && !context_flush_ready);
endmodule

// >>> tb/qie_mem.sv
`timescale 1ns/1ns
module qie_mem
(
  input wire logic clk,
  input wire logic rd_valid,
  input wire logic [63:0] rd_addr,
  input wire logic entry_width_sel,
  input wire logic [3:0] lag,
  output logic rd_ready,
  output logic data_valid,
  output logic [255:0] data_desc,
  input wire logic flush_req,
  output logic flush_done
);
  logic [255:0] mem [0:15];
  logic [3:0] n;
  initial
  begin
    rd_ready = 1'h0;
    data_valid = 1'h0;
    flush_done = 1'h0;
    data_desc = {64{4'hA}};
  end
  always
  begin
    @(negedge clk);
    if (rd_valid)
    begin
      repeat (lag) @(negedge clk);
      n = entry_width_sel ? rd_addr[8:5] : rd_addr[7:4];
      rd_ready = 1'h1;
      @(negedge clk);
      rd_ready = 1'h0;
      repeat (lag) @(negedge clk);
      data_desc = mem[n];
      data_valid = 1'h1;
      @(negedge clk);
      data_valid = 1'h0;
      // stale data flips so a late sample cannot match
      data_desc = ~data_desc;
    end
  end
  always @(negedge clk)
    flush_done <= flush_req && !flush_done;
endmodule

// >>> tb/test_queued_invalidation_engine.sv
`timescale 1ns/1ns
module test_queued_invalidation_engine;
  logic clk = 1'h0, rst_n = 1'h0, queue_enable_cmd = 1'h0, entry_width_sel = 1'h0;
  logic scalable_support = 1'h0, abort_support = 1'h0, queue_error_clear = 1'h0;
  logic timeout_error_flag = 1'h0, write_buffer_flush_needed = 1'h0;
  logic context_flush_ready = 1'h0, other_ready = 1'h0;
  logic [3:0] queue_size_log2 = 4'h0, lag = 4'h0;
  logic [1:0] translation_kind = 2'h0, g, m;
  logic [15:0] s;
  logic [63:0] queue_base_config = 64'h0000000100000000, rd_addr;
  logic [18:0] ring_tail = 19'h00000, ring_head;
  logic queue_on_status, queue_error_flag, rd_valid, rd_ready, data_valid;
  logic flush_req, flush_done, context_flush_valid, other_valid;
  logic [255:0] data_desc;
  logic [6:0] other_kind;
  qie_pkg::qie_req_t context_flush_request;
  int mismatches = 0, cmp_count = 0, i;
  always #2 clk = ~clk;
  qie_engine i_dut (.*);
  qie_mem i_mem (.*);
  task automatic report_and_stop();
    $display("mismatches %0d compares %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(string n, logic [63:0] e, logic [63:0] v);
    cmp_count++;
    if (v !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, v);
    end
  endtask
  task automatic lim(int j);
    if (j >= 300)
    begin
      mismatches++;
      $display("Error wait expected done seen stuck");
      report_and_stop();
    end
  endtask
  task automatic put(int n, logic [6:0] t, logic [1:0] gg, logic [15:0] d, logic [15:0] ss,
    logic [1:0] mm);
    i_mem.mem[n] = {206'h0, mm, ss, d, 4'h0, t[6:4], 3'h0, gg, t[3:0]};
    ring_tail = ring_tail + (entry_width_sel ? 19'h00020 : 19'h00010);
  endtask
  task automatic gm(int k);
    g = k < 2 ? 2'(k + 1) : 2'h3;
    m = k < 2 ? 2'h0 : 2'(k - 2);
    s = k < 2 ? 16'h0000 : 16'hABC8 + 16'(k);
  endtask
  task automatic pop(logic [1:0] gg, logic [15:0] d, logic [15:0] ss, logic [1:0] mm);
    qie_pkg::qie_req_t r;
    int j;
    r.scope = (translation_kind == 2'h1 && gg == 2'h2) ? 2'h1 : gg;
    r.domain_tag = translation_kind == 2'h1 ? 16'h0000 : d;
    // kept-bit mask per phantom_mask: none, bit 2, bits 2:1, bits 2:0 hidden
    r.requester_mask = mm == 2'h0 ? 16'hFFFF : mm == 2'h1 ? 16'hFFFB
                     : mm == 2'h2 ? 16'hFFF9 : 16'hFFF8;
    r.requester_number = ss & r.requester_mask;
    r.kind = 7'h01;
    @(negedge clk);
    for (j = 0; j < 300 && context_flush_valid !== 1'h1; j++)
      @(negedge clk);
    lim(j);
    chk("request", r, context_flush_request);
    context_flush_ready = 1'h1;
    @(negedge clk);
    context_flush_ready = 1'h0;
  endtask
  task automatic wait_head(logic [18:0] e);
    int j;
    for (j = 0; j < 300 && ring_head !== e; j++)
      @(negedge clk);
    lim(j);
    chk("head", e, ring_head);
  endtask
  task automatic wait_err();
    int j;
    for (j = 0; j < 300 && queue_error_flag !== 1'h1; j++)
      @(negedge clk);
    lim(j);
    chk("error", 1, queue_error_flag);
  endtask
  task automatic clr();
    queue_error_clear = 1'h1;
    @(negedge clk);
    queue_error_clear = 1'h0;
  endtask
  initial
  begin
    repeat (8) @(negedge clk);
    rst_n = 1'h1;
    repeat (3) @(negedge clk);
    queue_enable_cmd = 1'h1;
    repeat (2) @(negedge clk);
    chk("on", 1, queue_on_status);
    for (i = 0; i < 6; i++)
    begin
      gm(i);
      put(i, 7'h01, g, 16'h0042, s, m);
    end
    repeat (40) @(negedge clk);
    chk("stall", 1, ring_head <= 19'h00030);
    for (i = 0; i < 6; i++)
    begin
      gm(i);
      pop(g, 16'h0042, s, m);
    end
    wait_head(19'h00060);
    put(6, 7'h27, 2'h1, 16'h0000, 16'h0000, 2'h0);
    for (i = 0; i < 300 && other_valid !== 1'h1; i++)
      @(negedge clk);
    lim(i);
    chk("kind", 7'h27, other_kind);
    other_ready = 1'h1;
    @(negedge clk);
    other_ready = 1'h0;
    put(7, 7'h01, 2'h0, 16'h0000, 16'h0000, 2'h0);
    wait_err();
    repeat (20) @(negedge clk);
    chk("head", 19'h00070, ring_head);
    put(7, 7'h01, 2'h1, 16'h0042, 16'h0000, 2'h0);
    ring_tail = ring_tail - 19'h00010;
    clr();
    pop(2'h1, 16'h0042, 16'h0000, 2'h0);
    timeout_error_flag = 1'h1;
    put(8, 7'h01, 2'h1, 16'h0042, 16'h0000, 2'h0);
    repeat (30) @(negedge clk);
    chk("head", 19'h00080, ring_head);
    timeout_error_flag = 1'h0;
    pop(2'h1, 16'h0042, 16'h0000, 2'h0);
    write_buffer_flush_needed = 1'h1;
    lag = 4'h3;
    put(9, 7'h01, 2'h3, 16'h0007, 16'h0005, 2'h1);
    pop(2'h3, 16'h0007, 16'h0005, 2'h1);
    wait_head(19'h000A0);
    write_buffer_flush_needed = 1'h0;
    lag = 4'h0;
    queue_enable_cmd = 1'h0;
    repeat (2) @(negedge clk);
    chk("on", 0, queue_on_status);
    chk("head", 0, ring_head);
    ring_tail = 19'h00000;
    translation_kind = 2'h1;
    scalable_support = 1'h1;
    queue_enable_cmd = 1'h1;
    put(0, 7'h01, 2'h1, 16'h0042, 16'h0000, 2'h0);
    wait_err();
    chk("head", 0, ring_head);
    queue_enable_cmd = 1'h0;
    clr();
    repeat (2) @(negedge clk);
    ring_tail = 19'h00000;
    entry_width_sel = 1'h1;
    queue_enable_cmd = 1'h1;
    put(0, 7'h01, 2'h2, 16'h0042, 16'h0000, 2'h0);
    put(1, 7'h01, 2'h3, 16'h0043, 16'h0100, 2'h3);
    ring_tail = ring_tail + 19'h00010;
    pop(2'h2, 16'h0042, 16'h0000, 2'h0);
    pop(2'h3, 16'h0043, 16'h0100, 2'h3);
    repeat (20) @(negedge clk);
    chk("head", 19'h00040, ring_head);
    report_and_stop();
  end
endmodule
bind qie_engine qie_chk i_chk (.*);
